// ### bench/host_model.sv
// Purpose: Host side that sends framed command bytes.
// Assumes: Inputs change on the falling edge.
// Notes: Released data shows the inverse of its last value.
`timescale 1ns/1ps
module host_model (
  input wire logic CLK,
  output regctl_pkg::byte_in_t BYTE_IN,
  input wire logic BYTE_ACK
);
  import regctl_pkg::*;
  initial BYTE_IN = '0;
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic two,
                       output logic [1:0] ack);
    @(negedge CLK) BYTE_IN = '{1'b1, 1'b0, ~BYTE_IN.data, 1'b0};
    @(negedge CLK) BYTE_IN = '{1'b0, 1'b1, a, 1'b0};
    @(posedge CLK) ack = {BYTE_ACK, 1'b0};
    if (two) begin
      @(negedge CLK) BYTE_IN.data = d;
      @(posedge CLK) ack[0] = BYTE_ACK;
    end
    @(negedge CLK) BYTE_IN = '{1'b0, 1'b0, ~BYTE_IN.data, 1'b1};
    @(negedge CLK) BYTE_IN.stop = 1'b0;
  endtask : frame
endmodule : host_model

// ### bench/regctl_monitor.sv
// Purpose: Port checker for the command interpreter.
// Assumes: Outputs settle on the rising clock.
// Notes: Bound to every core instance.
`timescale 1ns/1ps
module regctl_monitor (
  input wire logic CLK,
  input wire logic SRST,
  input regctl_pkg::byte_in_t BYTE_IN,
  input wire logic BYTE_ACK,
  input wire logic RD_REQ,
  input wire logic [7:0] RD_ADDR,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic [7:0] REG_SETTINGS,
  input regctl_pkg::analog_ctl_t ANALOG_CTL
);
  import regctl_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_reset_state: assert property ($past(SRST) |-> REG_SETTINGS == REG_SET_RESET
    && !ANALOG_CTL.asleep && !ANALOG_CTL.sense_mode) else $error("bad reset state");
  a_awake_reg_on: assert property (!ANALOG_CTL.asleep |-> ANALOG_CTL.regulator_on)
    else $error("regulator off while awake");
  a_sleep_reg_bit: assert property (ANALOG_CTL.asleep |->
    ANALOG_CTL.regulator_on == !REG_SETTINGS[SLEEP_OFF_POS]) else $error("sleep regulator");
  a_volt_follow: assert property (ANALOG_CTL.regulator_voltage_bit == REG_SETTINGS[0])
    else $error("voltage bit");
  a_analog_sleep: assert property (ANALOG_CTL.analog_on == !ANALOG_CTL.asleep)
    else $error("analog section");
  a_sleep_keeps: assert property (!$past(SRST) && $changed(ANALOG_CTL.asleep) |->
    $stable(REG_SETTINGS)) else $error("settings changed by sleep");
  a_read_answer: assert property (RD_REQ && RD_ADDR == CMD_REG_SET |=> RD_VALID
    && RD_DATA == $past(REG_SETTINGS)) else $error("read answer");
  a_sleep_sense: assert property (ANALOG_CTL.asleep |=> $stable(ANALOG_CTL.sense_mode))
    else $error("sense changed asleep");
  a_ack_valid: assert property (BYTE_ACK |-> BYTE_IN.valid)
    else $error("stray ack");
  c_sleep_off: cover property (ANALOG_CTL.asleep && !ANALOG_CTL.regulator_on);
  c_sense: cover property (ANALOG_CTL.sense_mode);
  c_read_asleep: cover property (RD_VALID && ANALOG_CTL.asleep);
endmodule : regctl_monitor
bind regctl_core regctl_monitor regctl_monitor_inst (.CLK, .SRST, .BYTE_IN, .BYTE_ACK,
  .RD_REQ, .RD_ADDR, .RD_DATA, .RD_VALID, .REG_SETTINGS, .ANALOG_CTL);

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Host model frames every command.
// Notes: Row table first, then sense and select pairs, then reads and a reset.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t mismatch", $time); end end
module tb_top;
  import regctl_pkg::*;
  typedef struct packed {
    logic [7:0] a, d;
    logic two;
    logic [1:0] ack;
    logic [7:0] set;
    logic slp, sns;
  } row_t;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic rd_req = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic byte_ack, rd_valid;
  logic [7:0] rd_data, settings;
  logic [1:0] ack;
  byte_in_t byte_in;
  analog_ctl_t ctl;
  row_t r;
  int n_fail = 0, checks_done = 0, cycles = 0;
  logic [12:0] exp_out;
  // Sleep row keeps 0x02 to show the settings survive; last row offers a surplus byte
  row_t rows [10] = '{
    '{8'h07, 8'h01, 1'b1, 2'h3, 8'h01, 1'b0, 1'b0},
    '{8'h08, 8'h00, 1'b0, 2'h2, 8'h01, 1'b0, 1'b1},
    '{8'h06, 8'h03, 1'b1, 2'h3, 8'h01, 1'b0, 1'b1},
    '{8'h07, 8'h02, 1'b1, 2'h3, 8'h02, 1'b0, 1'b1},
    '{8'h05, 8'h00, 1'b0, 2'h2, 8'h02, 1'b1, 1'b1},
    '{8'h08, 8'h00, 1'b0, 2'h0, 8'h02, 1'b1, 1'b1},
    '{8'h07, 8'h00, 1'b1, 2'h3, 8'h00, 1'b1, 1'b1},
    '{8'h04, 8'h00, 1'b0, 2'h2, 8'h00, 1'b0, 1'b1},
    '{8'h12, 8'h00, 1'b0, 2'h2, 8'h00, 1'b0, 1'b0},
    '{8'h04, 8'hFF, 1'b1, 2'h2, 8'h00, 1'b0, 1'b0}
  };
  logic [7:0] sels [8] = '{CMD_SEL_0, CMD_SEL_1, CMD_SEL_2, CMD_SEL_3, CMD_SEL_4, CMD_SEL_5,
    CMD_SEL_6, CMD_SEL_7};
  host_model host_model_inst (.CLK(CLK), .BYTE_IN(byte_in), .BYTE_ACK(byte_ack));
  regctl_core regctl_core_inst (.CLK(CLK), .SRST(SRST), .BYTE_IN(byte_in), .BYTE_ACK(byte_ack),
    .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .REG_SETTINGS(settings), .ANALOG_CTL(ctl));
  initial forever #5 CLK = ~CLK;
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge CLK) rd_req = 1'b1;
    rd_addr = a;
    @(negedge CLK) rd_req = 1'b0;
    `CHK({rd_valid, rd_data}, {1'b1, e})
  endtask : rd
  task automatic close_out;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge CLK);
    SRST = 1'b0;
    `CHK({settings, ctl}, {8'h00, 5'h0C})
    foreach (rows[i]) begin
      r = rows[i];
      host_model_inst.frame(r.a, r.d, r.two, ack);
      `CHK(ack, r.ack)
      exp_out = {r.set, r.set[0], !r.slp | !r.set[1], !r.slp, r.sns, r.slp};
      `CHK({settings, ctl}, exp_out)
    end
    foreach (sels[i]) begin
      host_model_inst.frame(CMD_SENSE, 8'h00, 1'b0, ack);
      `CHK(ctl.sense_mode, 1'b1)
      host_model_inst.frame(sels[i], 8'h00, 1'b0, ack);
      `CHK(ctl.sense_mode, 1'b0)
    end
    host_model_inst.frame(CMD_REG_SET, 8'h03, 1'b1, ack);
    host_model_inst.frame(CMD_SLEEP, 8'h00, 1'b0, ack);
    rd(CMD_REG_SET, 8'h03);
    rd(8'h06, READ_ZERO);
    // Reset in mid-sleep must restore every default
    @(negedge CLK) SRST = 1'b1;
    @(negedge CLK) SRST = 1'b0;
    `CHK({settings, ctl}, {8'h00, 5'h0C})
    close_out();
  end
endmodule : tb_top

// ### rtl/regctl_core.sv
// Purpose: Command interpreter for regulator setting, current-sense mode and sleep mode.
// Assumes: Byte pulses already framed; reads come as a request with a register address.
// Notes: Commands outside this block's scope are acknowledged while awake and their bytes dropped; asleep they get no acknowledge.
`timescale 1ns/1ps

module regctl_core (
  input wire logic CLK,
  input wire logic SRST,
  input regctl_pkg::byte_in_t BYTE_IN,
  output logic BYTE_ACK,
  input wire logic RD_REQ,
  input wire logic [7:0] RD_ADDR,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic [7:0] REG_SETTINGS,
  output regctl_pkg::analog_ctl_t ANALOG_CTL
);
  import regctl_pkg::*;

  // ************************************
  // Command kinds and state
  // ************************************
  typedef enum {
    K_WAKE,
    K_SLEEP,
    K_REG_SET,
    K_SENSE,
    K_SELECT,
    K_OTHER
  } cmd_kind_t;

  typedef struct packed {
    cmd_state_t st;
    logic [7:0] settings;
    logic sense;
    logic sleep;
    logic [7:0] rd_data;
    logic rd_valid;
    analog_ctl_t ctl;
  } core_state_t;

  core_state_t state_r;
  core_state_t state_nxt;
  cmd_kind_t kind;

  // ************************************
  // Reset values
  // ************************************
  // Awake after reset, so the regulator is on whatever the off bit says
  localparam analog_ctl_t CTL_RESET = '{
    regulator_voltage_bit: REG_SET_RESET[VSEL_POS],
    regulator_on: 1'b1,
    analog_on: 1'b1,
    sense_mode: 1'b0,
    asleep: 1'b0
  };

  localparam core_state_t CORE_RESET = '{
    st: ST_IDLE,
    settings: REG_SET_RESET,
    sense: 1'b0,
    sleep: 1'b0,
    rd_data: READ_ZERO,
    rd_valid: 1'b0,
    ctl: CTL_RESET
  };

  // ************************************
  // Decoding helpers
  // ************************************
  // Select addresses form no simple bit pattern, so each is listed
  function automatic logic is_input_select(input logic [7:0] a);
    is_input_select = (a == CMD_SEL_0) || (a == CMD_SEL_1) || (a == CMD_SEL_2)
                   || (a == CMD_SEL_3) || (a == CMD_SEL_4) || (a == CMD_SEL_5)
                   || (a == CMD_SEL_6) || (a == CMD_SEL_7);
  endfunction : is_input_select

  function automatic cmd_kind_t classify(input logic [7:0] a);
    if (a == CMD_WAKE) begin
      classify = K_WAKE;
    end else if (a == CMD_SLEEP) begin
      classify = K_SLEEP;
    end else if (a == CMD_REG_SET) begin
      classify = K_REG_SET;
    end else if (a == CMD_SENSE) begin
      classify = K_SENSE;
    end else if (is_input_select(a)) begin
      classify = K_SELECT;
    end else begin
      classify = K_OTHER;
    end
  endfunction : classify

  // Asleep, only wake and the regulator settings get through
  function automatic logic allowed_asleep(input cmd_kind_t k);
    allowed_asleep = (k == K_WAKE) || (k == K_REG_SET);
  endfunction : allowed_asleep

  // Only the settings register holds a readable value here
  function automatic logic [7:0] read_value(input logic [7:0] a, input logic [7:0] s);
    if (a == CMD_REG_SET) begin
      read_value = s;
    end else begin
      read_value = READ_ZERO;
    end
  endfunction : read_value

  // Awake forces the regulator on; the off bit only counts asleep
  function automatic analog_ctl_t levels(input logic [7:0] s, input logic slp,
                                         input logic sns);
    levels.regulator_voltage_bit = s[VSEL_POS];
    levels.regulator_on = !slp || !s[SLEEP_OFF_POS];
    levels.analog_on = !slp;
    levels.sense_mode = sns;
    levels.asleep = slp;
  endfunction : levels

  // ************************************
  // Next state and acknowledge
  // ************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.rd_valid = 1'b0;
    BYTE_ACK = 1'b0;
    // Decoded every cycle; only the address byte uses it
    kind = classify(BYTE_IN.data);
    if (BYTE_IN.start) begin
      // A new frame always restarts decoding, even mid-command
      state_nxt.st = ST_ADDR;
    end else if (BYTE_IN.stop) begin
      state_nxt.st = ST_IDLE;
    end else if (BYTE_IN.valid) begin
      case (state_r.st)
        ST_ADDR: begin
          if (state_r.sleep && !allowed_asleep(kind)) begin
            // Ignored while asleep: no acknowledge, rest of frame dropped
            state_nxt.st = ST_DONE;
          end else begin
            BYTE_ACK = 1'b1;
            case (kind)
              K_REG_SET: begin
                state_nxt.st = ST_DATA;
              end
              K_WAKE: begin
                state_nxt.sleep = 1'b0;
                state_nxt.st = ST_DONE;
              end
              K_SLEEP: begin
                state_nxt.sleep = 1'b1;
                state_nxt.st = ST_DONE;
              end
              K_SENSE: begin
                state_nxt.sense = 1'b1;
                state_nxt.st = ST_DONE;
              end
              K_SELECT: begin
                state_nxt.sense = 1'b0;
                state_nxt.st = ST_DONE;
              end
              default: begin
                // Gain, offset and other commands leave sense mode alone
                state_nxt.st = ST_SKIP;
              end
            endcase
          end
        end
        ST_DATA: begin
          BYTE_ACK = 1'b1;
          state_nxt.settings = BYTE_IN.data;
          state_nxt.st = ST_DONE;
        end
        ST_SKIP: begin
          // Parameter bytes of commands handled elsewhere
          BYTE_ACK = 1'b1;
        end
        default: begin
          // Surplus byte after a complete command is refused
          BYTE_ACK = 1'b0;
        end
      endcase
    end
    // Read port
    if (RD_REQ) begin
      // Retained settings read the same awake or asleep
      state_nxt.rd_data = read_value(RD_ADDR, state_r.settings);
      state_nxt.rd_valid = 1'b1;
    end
    // Levels built from the next values so they move on the same edge
    state_nxt.ctl = levels(state_nxt.settings, state_nxt.sleep, state_nxt.sense);
  end

  // ************************************
  // Registers
  // ************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= CORE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************
  // Outputs
  // ************************************
  assign RD_DATA = state_r.rd_data;
  assign RD_VALID = state_r.rd_valid;
  assign REG_SETTINGS = state_r.settings;
  assign ANALOG_CTL = state_r.ctl;

endmodule : regctl_core

// ### rtl/regctl_pkg.sv
// Purpose: Shared constants and carriers for the regulator, sleep and sense command logic.
// Assumes: An outer byte engine handles the two-wire framing and device address.
// Notes: Command addresses are the register addresses sent as the first byte.
package regctl_pkg;

  // ************************************
  // Command addresses
  // ************************************
  localparam logic [7:0] CMD_WAKE = 8'h04;
  localparam logic [7:0] CMD_SLEEP = 8'h05;
  localparam logic [7:0] CMD_REG_SET = 8'h07;
  localparam logic [7:0] CMD_SENSE = 8'h08;
  localparam logic [7:0] CMD_SEL_0 = 8'h10;
  localparam logic [7:0] CMD_SEL_1 = 8'h12;
  localparam logic [7:0] CMD_SEL_2 = 8'h14;
  localparam logic [7:0] CMD_SEL_3 = 8'h15;
  localparam logic [7:0] CMD_SEL_4 = 8'h18;
  localparam logic [7:0] CMD_SEL_5 = 8'h1A;
  localparam logic [7:0] CMD_SEL_6 = 8'h1C;
  localparam logic [7:0] CMD_SEL_7 = 8'h1E;

  // ************************************
  // Regulator settings layout and reset
  // ************************************
  localparam int VSEL_POS = 0;
  localparam int SLEEP_OFF_POS = 1;
  localparam logic [7:0] REG_SET_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_DONE,
    ST_SKIP
  } cmd_state_t;

  // Byte stream from the serial engine
  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
    logic stop;
  } byte_in_t;

  // Analog control levels
  typedef struct packed {
    logic regulator_voltage_bit;
    logic regulator_on;
    logic analog_on;
    logic sense_mode;
    logic asleep;
  } analog_ctl_t;

endpackage : regctl_pkg
